// ==== hw/host_fifo.v ====
// Synchronous valid/ready FIFO used on the read data path
`timescale 1ns/1ns
module host_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_ff;
  reg [AW-1:0] rp_ff;
  reg [AW:0] cnt_ff;
  wire push = i_ce && i_in_valid && o_in_ready;
  wire pop = i_ce && o_out_valid && i_out_ready;
  // Full and empty come from a count, so no pointer wrap ambiguity
  assign o_in_ready = (cnt_ff != DEPTH[AW:0]);
  assign o_out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign o_out_data = mem[rp_ff];
  always @(posedge i_clk) begin
    if (push) begin
      mem[wp_ff] <= i_in_data;
    end
  end
  // Pointers and count
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      wp_ff <= {AW{1'b0}};
      rp_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// ==== hw/nand_host.v ====
// Pin-level host controller for an x16 NAND flash device
`timescale 1ns/1ns
`include "nand_host_defs.vh"
// How it works
// - Shared bus carries command, address, write data out and read data back.
// - Commands and addresses use the low byte; upper lanes carry data only.
// - Column address sets the page start for serial access.
// - Host drives all unused address bits and upper lanes low.
// - Host sends two column cycles then two row cycles, fewer when i_req_naddr is 1 to 3, eight (last four zero) when it is 0.
module nand_host (
  input wire i_clk,
  input wire i_rstn,
  input wire i_ce,
  input wire i_req_valid,
  output reg o_req_ready,
  input wire [1:0] i_req_op,
  input wire [`BUS_W-1:0] i_req_data,
  input wire [`ADDR_W-1:0] i_req_addr,
  input wire [2:0] i_req_naddr,
  output reg o_rd_valid,
  input wire i_rd_ready,
  output reg [`BUS_W-1:0] o_rd_data,
  input wire i_wp_allow,
  input wire i_pre_enable,
  output reg o_cle,
  output reg o_ale,
  output reg o_chip_sel_n,
  output reg o_write_strobe_n,
  output reg o_read_strobe_n,
  output reg o_write_protect_n,
  output reg o_pre,
  output reg [`BUS_W-1:0] o_bus_out,
  output reg o_bus_oe_n,
  input wire [`BUS_W-1:0] i_bus_in,
  input wire i_ready_busy,
  output reg o_busy
);
  localparam S_IDLE = 5'b00001;
  localparam S_WLOW = 5'b00010;
  localparam S_WHIGH = 5'b00100;
  localparam S_RLOW = 5'b01000;
  localparam S_RCAP = 5'b10000;
  reg [4:0] state_ff;
  reg [`PHASE_W-1:0] cnt_ff;
  reg [2:0] acyc_ff;
  reg [2:0] alast_ff;
  reg [`ADDR_W-1:0] addr_ff;
  reg [`BUS_W-1:0] rword_ff;
  reg rpush_ff;
  reg [7:0] abyte;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`BUS_W-1:0] fifo_out_data;
  wire fifo_pop;
  wire [2:0] nxt_acyc;
  // Read words go through the FIFO; a full FIFO stalls further read strobes
  host_fifo #(.WIDTH(`BUS_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_in_valid(rpush_ff),
    .o_in_ready(fifo_in_ready),
    .i_in_data(rword_ff),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data)
  );
  // Output stage refills whenever it is empty or being taken
  assign fifo_pop = !o_rd_valid || i_rd_ready;
  // Read port comes from flops, so the sink never sees the FIFO read mux;
  // the price is one cycle of latency and one extra word of slack
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= {`BUS_W{1'b0}};
    end else if (i_ce && fifo_pop) begin
      o_rd_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        o_rd_data <= fifo_out_data;
      end
    end
  end
  // Index of the address cycle that follows the current one
  assign nxt_acyc = acyc_ff + 3'h1;
  // Byte for the next address cycle, unused bits forced low; it goes out
  // with the next strobe fall, so it never races a strobe rise
  always @* begin
    abyte = 8'h00;
    case (nxt_acyc)
      3'h0: abyte = addr_ff[`COL_LO_MSB:0];
      3'h1: abyte = {5'h00, addr_ff[`COL_HI_MSB:`COL_HI_LSB]};
      3'h2: abyte = addr_ff[`ROW_LO_MSB:`ROW_LO_LSB];
      3'h3: abyte = addr_ff[`ROW_HI_MSB:`ROW_HI_LSB];
      default: abyte = 8'h00;
    endcase
  end
  // Main sequencer; pins all come from flops
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      state_ff <= S_IDLE;
      cnt_ff <= {`PHASE_W{1'b0}};
      acyc_ff <= 3'h0;
      alast_ff <= 3'h0;
      addr_ff <= {`ADDR_W{1'b0}};
      rword_ff <= {`BUS_W{1'b0}};
      rpush_ff <= 1'b0;
      o_req_ready <= 1'b0;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_chip_sel_n <= 1'b1;
      o_write_strobe_n <= 1'b1;
      o_read_strobe_n <= 1'b1;
      o_write_protect_n <= 1'b0;
      o_pre <= 1'b0;
      o_bus_out <= {`BUS_W{1'b0}};
      o_bus_oe_n <= 1'b1;
      o_busy <= 1'b1;
    end else if (i_ce) begin
      rpush_ff <= 1'b0;
      o_write_protect_n <= i_wp_allow;
      o_pre <= i_pre_enable;
      o_busy <= !i_ready_busy;
      case (state_ff)
        S_IDLE: begin
          o_req_ready <= 1'b1;
          // Chip select kept low while busy; device ignores release anyway
          o_chip_sel_n <= !(i_req_valid || !i_ready_busy);
          if (i_req_valid && o_req_ready) begin
            o_req_ready <= 1'b0;
            o_chip_sel_n <= 1'b0;
            cnt_ff <= {`PHASE_W{1'b0}};
            if (i_req_op == `OP_RDATA) begin
              // Reads wait for ready and for FIFO room
              state_ff <= S_RLOW;
              o_bus_oe_n <= 1'b1;
            end else begin
              state_ff <= S_WLOW;
              o_write_strobe_n <= 1'b0;
              o_bus_oe_n <= 1'b0;
              o_cle <= (i_req_op == `OP_CMD);
              o_ale <= (i_req_op == `OP_ADDR);
              addr_ff <= i_req_addr;
              acyc_ff <= 3'h0;
              alast_ff <= (i_req_naddr > `ADDR_CYCLES) ? `ADDR_CYCLES - 3'h1 : i_req_naddr - 3'h1;
              if (i_req_op == `OP_WDATA) begin
                o_bus_out <= i_req_data;
              end else if (i_req_op == `OP_CMD) begin
                o_bus_out <= {8'h00, i_req_data[7:0]};
              end else begin
                o_bus_out <= {8'h00, i_req_addr[`COL_LO_MSB:0]};
              end
            end
          end
        end
        S_WLOW: begin
          // Strobe low time rounded up to whole cycles
          if (cnt_ff >= `WE_LOW_CYC - `PHASE_ONE) begin
            o_write_strobe_n <= 1'b1;
            cnt_ff <= {`PHASE_W{1'b0}};
            state_ff <= S_WHIGH;
          end else begin
            cnt_ff <= cnt_ff + `PHASE_ONE;
          end
        end
        S_WHIGH: begin
          // Bus held one cycle past the rising edge for hold time
          if (o_ale && acyc_ff != alast_ff) begin
            acyc_ff <= nxt_acyc;
            o_write_strobe_n <= 1'b0;
            o_bus_out <= {8'h00, abyte};
            state_ff <= S_WLOW;
          end else begin
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_bus_oe_n <= 1'b1;
            state_ff <= S_IDLE;
          end
        end
        S_RLOW: begin
          if (cnt_ff == {`PHASE_W{1'b0}} && o_read_strobe_n) begin
            if (i_ready_busy && fifo_in_ready && !rpush_ff) begin
              o_read_strobe_n <= 1'b0;
            end
          end else if (cnt_ff >= `RD_ACCESS_CYC) begin
            cnt_ff <= {`PHASE_W{1'b0}};
            state_ff <= S_RCAP;
          end else begin
            cnt_ff <= cnt_ff + `PHASE_ONE;
          end
        end
        S_RCAP: begin
          rword_ff <= i_bus_in;
          rpush_ff <= 1'b1;
          o_read_strobe_n <= 1'b1;
          state_ff <= S_IDLE;
        end
        default: begin
          state_ff <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== hw/nand_host_defs.vh ====
// Constants for the x16 NAND pin-level host controller
`ifndef NAND_HOST_DEFS_VH
`define NAND_HOST_DEFS_VH
`define CLK_PERIOD_NS 40
`define WE_LOW_NS 25
`define WE_LOW_CYC ((`WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_ACCESS_NS 30
`define RD_ACCESS_CYC ((`RD_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PHASE_W 4
`define PHASE_ONE 4'h1
`define ADDR_CYCLES 3'h4
`define COL_LO_MSB 7
`define COL_HI_MSB 10
`define COL_HI_LSB 8
`define ROW_LO_MSB 18
`define ROW_LO_LSB 11
`define ROW_HI_MSB 26
`define ROW_HI_LSB 19
`define ADDR_W 27
`define BUS_W 16
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define OP_CMD 2'h0
`define OP_ADDR 2'h1
`define OP_WDATA 2'h2
`define OP_RDATA 2'h3
`endif

// ==== verification/nand_dev_model.sv ====
// Behavioural x16 NAND device with a 16-word page register
`timescale 1ns/1ns
module nand_dev_model #(parameter BUSY_CYC = 6) (
  input wire i_clk,
  input wire i_cle,
  input wire i_ale,
  input wire i_chip_sel_n,
  input wire i_write_strobe_n,
  input wire i_read_strobe_n,
  input wire i_write_protect_n,
  input wire [15:0] i_bus,
  output wire [15:0] o_bus,
  output wire o_ready_busy
);
  reg [15:0] mem_ff [0:15];
  reg [10:0] col_ff;
  reg [15:0] row_ff;
  reg [2:0] acnt_ff;
  reg [15:0] dout_ff;
  integer busy_cnt = 0;
  // Everything is taken on the strobe rise; the array itself is not modelled
  always @(posedge i_write_strobe_n) begin
    if (!i_chip_sel_n && i_cle) begin
      if (i_bus[7:0] == 8'h00 || i_bus[7:0] == 8'h80)
        acnt_ff = 3'h0;
      if (i_bus[7:0] == 8'h30 || (i_bus[7:0] == 8'h10 && i_write_protect_n))
        busy_cnt = BUSY_CYC;
    end else if (!i_chip_sel_n && i_ale && acnt_ff < 3'h4) begin
      case (acnt_ff)
        3'h0: col_ff[7:0] = i_bus[7:0];
        3'h1: col_ff[10:8] = i_bus[2:0];
        3'h2: row_ff[7:0] = i_bus[7:0];
        default: row_ff[15:8] = i_bus[7:0];
      endcase
      acnt_ff = acnt_ff + 3'h1;
    end else if (!i_chip_sel_n && !i_ale) begin
      mem_ff[col_ff[3:0]] = i_bus;
      col_ff = col_ff + 11'h001;
    end
  end
  // Busy counts down even with chip select released
  always @(posedge i_clk) begin
    if (busy_cnt > 0)
      busy_cnt <= busy_cnt - 1;
  end
  // Each read strobe fall gives the next word and steps the column
  always @(negedge i_read_strobe_n) begin
    dout_ff <= mem_ff[col_ff[3:0]];
    col_ff <= col_ff + 11'h001;
  end
  // Released bus shows the inverse of the last word, never a held value
  assign o_bus = (!i_chip_sel_n && !i_read_strobe_n) ? dout_ff : ~dout_ff;
  assign o_ready_busy = (busy_cnt == 0);
endmodule

// ==== verification/nand_host_props.sv ====
// Pin-level checks for the NAND host controller
`timescale 1ns/1ns
module nand_host_props (
  input wire i_clk,
  input wire i_rstn,
  input wire i_ready_busy,
  input wire i_wp_allow,
  input wire o_cle,
  input wire o_ale,
  input wire o_chip_sel_n,
  input wire o_write_strobe_n,
  input wire o_read_strobe_n,
  input wire [15:0] o_bus_out,
  input wire o_bus_oe_n,
  input wire o_busy,
  input wire o_write_protect_n,
  input wire o_rd_valid
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // Strobe, latch, bus, busy, protect and read-return relations; the clock enable is held high by the bench
  property p_lane; !o_write_strobe_n && (o_cle || o_ale) |-> o_bus_out[15:8] == 8'h00; endproperty
  a_lane: assert property (p_lane) else $error("upper lane set");
  property p_hold; !o_write_strobe_n |=> $stable(o_bus_out) && !o_bus_oe_n; endproperty
  a_hold: assert property (p_hold) else $error("bus moved at strobe");
  property p_sel; !o_write_strobe_n || !o_read_strobe_n |-> !o_chip_sel_n; endproperty
  a_sel: assert property (p_sel) else $error("strobe unselected");
  property p_excl; !(o_cle && o_ale); endproperty
  a_excl: assert property (p_excl) else $error("both latches high");
  property p_rd; !o_read_strobe_n |-> o_bus_oe_n; endproperty
  a_rd: assert property (p_rd) else $error("host drives in read");
  property p_busy; $fell(i_ready_busy) |=> o_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy missed");
  property p_wp; 1'h1 |=> o_write_protect_n == $past(i_wp_allow); endproperty
  a_wp: assert property (p_wp) else $error("protect pin wrong");
  property p_rdv; $fell(o_read_strobe_n) |-> ##[1:6] o_rd_valid; endproperty
  a_rdv: assert property (p_rdv) else $error("read word lost");
endmodule
bind nand_host nand_host_props u_props (.*);

// ==== verification/testbench.sv ====
// Random page write and read-back bench for the NAND host controller
`timescale 1ns/1ns
module testbench;
  reg i_clk = 1'h0, i_rstn = 1'h0, vld = 1'h0, rrdy = 1'h0, hold = 1'h0, wp = 1'h1, saw = 1'h0, pre = 1'h0;
  reg [1:0] op = 2'h0;
  reg [15:0] dat = 16'h0000;
  reg [26:0] adr = 27'h0000000;
  reg [2:0] na = 3'h4;
  reg [15:0] emem [0:15];
  reg [15:0] got [$];
  reg [15:0] row;
  reg [10:0] col;
  wire [15:0] bout, rdata, dq;
  wire cle, ale, csn, wen, ren, oen, rb, rv, rq, wpn, bsy, pr;
  integer bad_count = 0, check_count = 0, k, i;
  nand_host dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'h1), .i_req_valid(vld), .o_req_ready(rq),
    .i_req_op(op), .i_req_data(dat), .i_req_addr(adr), .i_req_naddr(na), .o_rd_valid(rv), .i_rd_ready(rrdy),
    .o_rd_data(rdata), .i_wp_allow(wp), .i_pre_enable(pre), .o_cle(cle), .o_ale(ale), .o_chip_sel_n(csn),
    .o_write_strobe_n(wen), .o_read_strobe_n(ren), .o_write_protect_n(wpn), .o_pre(pr), .o_bus_out(bout),
    .o_bus_oe_n(oen), .i_bus_in(oen ? dq : bout), .i_ready_busy(rb), .o_busy(bsy));
  nand_dev_model dev (.i_clk(i_clk), .i_cle(cle), .i_ale(ale), .i_chip_sel_n(csn), .i_write_strobe_n(wen),
    .i_read_strobe_n(ren), .i_write_protect_n(wpn), .i_bus(bout), .o_bus(dq), .o_ready_busy(rb));
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  // Collect read words; the sink stalls at random unless held off
  always @(posedge i_clk) begin
    if (rv && rrdy) got.push_back(rdata);
    if (bsy) saw <= 1'h1;
  end
  always @(negedge i_clk) rrdy <= hold ? 1'h0 : $urandom % 2;
  function [26:0] addr_of(input [10:0] c, input [15:0] r);
    addr_of = {r, c};
  endfunction
  task chk(input string n, input [26:0] s, input [26:0] e);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("ERROR %s exp %h got %h", n, e, s);
      end
    end
  endtask
  // Request held from a falling edge until the edge that takes it
  task req(input [1:0] o, input [15:0] d);
    begin
      @(negedge i_clk);
      op = o;
      dat = d;
      vld = 1'h1;
      k = 0;
      while (rq !== 1'h1 && k < 500) begin
        @(negedge i_clk);
        k = k + 1;
      end
      if (k == 500) bad_count = bad_count + 1;
      @(negedge i_clk);
      vld = 1'h0;
    end
  endtask
  // Program n words at a random column, then read them back
  task pg(input integer n, input h);
    begin
      row = $urandom;
      col = $urandom % 1056;
      pre = $urandom % 2;
      adr = addr_of(col, row);
      req(2'h0, 16'h0080);
      chk("power-on read select", pr, pre);
      req(2'h1, 16'h0000);
      for (i = 0; i < n; i = i + 1) begin
        emem[i] = $urandom;
        req(2'h2, emem[i]);
      end
      saw = 1'h0;
      req(2'h0, 16'h0010);
      for (k = 0; k < 40 && !(saw && rb); k = k + 1) @(negedge i_clk);
      chk("program busy", saw, wp);
      req(2'h0, 16'h0000);
      req(2'h1, 16'h0000);
      adr = ~adr;
      na = 3'h1;
      req(2'h1, 16'h0000);
      na = 3'h4;
      req(2'h0, 16'h0030);
      chk("row", dev.row_ff, row);
      chk("column", dev.col_ff, col);
      got.delete();
      hold = h;
      for (i = 0; i < n; i = i + 1) req(2'h3, 16'h0000);
      hold = 1'h0;
      for (k = 0; k < 300 && got.size() < n; k = k + 1) @(negedge i_clk);
      chk("count", got.size(), n);
      for (i = 0; i < n && i < got.size(); i = i + 1) chk("data", got[i], emem[i]);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    k = $urandom(5);
    repeat (7) @(negedge i_clk);
    chk("reset pins", {csn, oen, wpn}, 3'h6);
    @(negedge i_clk);
    i_rstn = 1'h1;
    pg(4, 1'h0);
    $display("test 1 done");
    pg(16, 1'h1);
    $display("test 2 done");
    wp = 1'h0;
    pg(2, 1'h0);
    $display("test 3 done");
    print_verdict;
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #1200000;
    bad_count = bad_count + 1;
    print_verdict;
  end
endmodule
